// File: logic/ppp_regs.vh
// Constants of the parallel programming port: commands, action codes, timing.
// Assumes a 100 MHz system clock; included by ppp_port.v only.
`ifndef PPP_REGS_VH
`define PPP_REGS_VH
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEPROM 8'h03
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
`define PPP_FUSE_LO_RST 8'hff
`define PPP_FUSE_HI_RST 8'hff
`define PPP_FUSE_EXT_RST 8'hff
`define PPP_LOCK_RST 8'hff
`define PPP_CLK_MHZ 100
`define PPP_T_FLASH_US 4500
`define PPP_T_EEPROM_US 4000
`define PPP_T_FUSE_US 4500
`endif

// File: logic/ppp_port.v
// Parallel programming port of the flash, data EEPROM, fuse and lock bytes.
// Assumes all pins already synchronous to clk_sys_i; strobes are levels,
// edges are detected here. Data pins are split into in, out and enable.
// Function
// R1 - Clock pulse with action 10 loads command
// R2 - Action 00, byte 0: address low byte
// R3 - Action 01, byte 0: data low byte
// R4 - Action 01, byte 1: data high byte
// R5 - Page latch stores data word in buffer
// R6 - Low address bits pick word, rest page
// R7 - Action 00, byte 1: address high byte
// R8 - Write strobe programs flash page, busy low
// R9 - Programmer fills buffer, then writes page
// R10 - Command zero ends session, clears write state
// R11 - Command 11h: EEPROM page buffer and write
// R12 - Command 02h: drive flash word bytes
// R13 - Command 03h: drive EEPROM byte
// R14 - Command 40h writes selected fuse byte
// R15 - Command 20h programs protection bits with zeros
// R16 - Mode 3 blocks further protection writes; code still writes them under command 40h with selects 11
// R17 - Protection bits cleared only by erase
// R18 - Ready output low while busy
// R19 - Data driven only while enable low
// R20 - Action 11 changes nothing
// R21 - Sample on clock rise; ignore strobes busy
`timescale 1ns/1ns
`include "ppp_regs.vh"
module ppp_port #(
   parameter FLASH_AW = 13,
   parameter WORD_BITS = 6,
   parameter EE_AW = 9,
   parameter EE_WORD_BITS = 2,
   parameter T_FLASH_CYC = `PPP_T_FLASH_US * `PPP_CLK_MHZ,
   parameter T_EEPROM_CYC = `PPP_T_EEPROM_US * `PPP_CLK_MHZ,
   parameter T_FUSE_CYC = `PPP_T_FUSE_US * `PPP_CLK_MHZ
) (
   input wire clk_sys_i,
   input wire rst_b_i,
   input wire load_clock_pin_i,
   input wire action_select_hi_i,
   input wire action_select_lo_i,
   input wire byte_select_a_i,
   input wire byte_select_b_i,
   input wire page_buffer_latch_i,
   input wire write_strobe_b_i,
   input wire output_enable_b_i,
   input wire [7:0] data_in_i,
   output reg [7:0] data_out_o,
   output reg [7:0] data_oe_o,
   output reg ready_not_busy_o,
   output reg [7:0] fuse_low_o,
   output reg [7:0] fuse_high_o,
   output reg [7:0] fuse_ext_o,
   output reg [7:0] protect_bits_o,
   input wire chip_erase_done_i
);
   // Array sizes and sequencer states
   localparam FLASH_WORDS = 1 << FLASH_AW;
   localparam PAGE_WORDS = 1 << WORD_BITS;
   localparam EE_BYTES = 1 << EE_AW;
   localparam EE_PAGE = 1 << EE_WORD_BITS;
   localparam ST_IDLE = 2'h0;
   localparam ST_FLASH = 2'h1;
   localparam ST_EE = 2'h2;
   localparam ST_CFG = 2'h3;

   // Memories and page buffers; flash stored as 16-bit words
   // Memories are not reset; unwritten locations read as unknown
   reg [15:0] flash_mem [0:FLASH_WORDS-1];
   reg [7:0] ee_mem [0:EE_BYTES-1];
   reg [15:0] fpage_buf [0:PAGE_WORDS-1];
   reg [7:0] epage_buf [0:EE_PAGE-1];
   reg [PAGE_WORDS-1:0] fpage_vld_reg;
   reg [EE_PAGE-1:0] epage_vld_reg;

   // Loaded command, address and data bytes
   reg [7:0] cmd_reg;
   reg [7:0] addr_lo_reg;
   reg [7:0] addr_hi_reg;
   reg [7:0] data_lo_reg;
   reg [7:0] data_hi_reg;
   // Sequencer state and busy timer
   reg [1:0] state_reg;
   reg [31:0] busy_cnt_reg;
   // Previous strobe levels for edge detection
   reg clk_d_reg;
   reg latch_d_reg;
   reg wr_d_reg;
   reg [1:0] cfg_sel_reg;
   integer i;

   // Action code and full 16-bit address
   wire [1:0] action = {action_select_hi_i, action_select_lo_i};
   wire [15:0] addr = {addr_hi_reg, addr_lo_reg};
   wire clk_rise = load_clock_pin_i & ~clk_d_reg;
   wire latch_rise = page_buffer_latch_i & ~latch_d_reg;
   wire wr_fall = ~write_strobe_b_i & wr_d_reg;
   wire idle = (state_reg == ST_IDLE);
   // Protection mode 3: both bits programmed (zero)
   wire lock_mode3 = ~protect_bits_o[0] & ~protect_bits_o[1];

   // Decoded requests; each is taken only while the sequencer is idle [R21]
   // A no-operation command load ends the page session [R10]
   wire nop_load = clk_rise && action == `PPP_ACT_CMD && !byte_select_a_i &&
                   data_in_i == `PPP_CMD_NOP;
   // Flash latch needs the high byte select; EEPROM latch does not [R5] [R11]
   wire flash_latch = latch_rise && byte_select_a_i && cmd_reg == `PPP_CMD_WR_FLASH;
   wire ee_latch = latch_rise && cmd_reg == `PPP_CMD_WR_EEPROM;

   // Flash word address; the page part also takes the upper low-byte bits
   function [FLASH_AW-1:0] flash_word;
      input [15:0] a;
      begin
         flash_word = a[FLASH_AW-1:0];
      end
   endfunction

   // Page number of a flash word address, used at the page commit [R6]
   function [FLASH_AW-WORD_BITS-1:0] flash_page;
      input [15:0] a;
      begin
         flash_page = a[FLASH_AW-1:WORD_BITS];
      end
   endfunction

   // Word slot within the flash page buffer, from the low address byte
   function [WORD_BITS-1:0] flash_slot;
      input [7:0] a;
      begin
         flash_slot = a[WORD_BITS-1:0];
      end
   endfunction

   // Page number of an EEPROM byte address
   function [EE_AW-EE_WORD_BITS-1:0] ee_page;
      input [15:0] a;
      begin
         ee_page = a[EE_AW-1:EE_WORD_BITS];
      end
   endfunction

   // Byte slot within the EEPROM page buffer
   function [EE_WORD_BITS-1:0] ee_slot;
      input [7:0] a;
      begin
         ee_slot = a[EE_WORD_BITS-1:0];
      end
   endfunction

   // Edge detectors on the strobes
   // Reset levels equal the idle pin levels, so no false edge follows reset
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_d_reg <= 1'b0;
         latch_d_reg <= 1'b0;
         wr_d_reg <= 1'b1;
      end else begin
         clk_d_reg <= load_clock_pin_i;
         latch_d_reg <= page_buffer_latch_i;
         wr_d_reg <= write_strobe_b_i;
      end
   end

   // Command, address and data loading on clock rise
   // Loads under a busy sequencer leave no trace at all
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_reg <= `PPP_CMD_NOP;
         addr_lo_reg <= 8'h00;
         addr_hi_reg <= 8'h00;
         data_lo_reg <= 8'h00;
         data_hi_reg <= 8'h00;
      end else if (clk_rise && idle) begin // [R21]
         case (action)
            `PPP_ACT_CMD: begin
               if (!byte_select_a_i)
                  cmd_reg <= data_in_i; // [R1]
            end
            `PPP_ACT_ADDR: begin
               if (byte_select_a_i)
                  addr_hi_reg <= data_in_i; // [R7]
               else
                  addr_lo_reg <= data_in_i; // [R2]
            end
            `PPP_ACT_DATA: begin
               if (byte_select_a_i)
                  data_hi_reg <= data_in_i; // [R4]
               else
                  data_lo_reg <= data_in_i; // [R3]
            end
            default: ; // Idle action holds everything [R20]
         endcase
      end
   end

   // Page buffers; valid masks restrict the page write to latched words.
   // No reset here: only latched slots are ever committed, so stale
   // contents of unlatched slots never reach the memories.
   always @(posedge clk_sys_i) begin
      if (idle && flash_latch)
         fpage_buf[flash_slot(addr_lo_reg)] <= {data_hi_reg, data_lo_reg}; // [R5] [R6]
      if (idle && ee_latch)
         epage_buf[ee_slot(addr_lo_reg)] <= data_lo_reg; // [R11]
   end

   // Self-timed programming sequencer and configuration bytes
   // Erase clear is placed first so a same-cycle lock commit still wins
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= ST_IDLE;
         busy_cnt_reg <= 32'h0000_0000;
         ready_not_busy_o <= 1'b1;
         fpage_vld_reg <= {PAGE_WORDS{1'b0}};
         epage_vld_reg <= {EE_PAGE{1'b0}};
         cfg_sel_reg <= 2'h0;
         fuse_low_o <= `PPP_FUSE_LO_RST;
         fuse_high_o <= `PPP_FUSE_HI_RST;
         fuse_ext_o <= `PPP_FUSE_EXT_RST;
         protect_bits_o <= `PPP_LOCK_RST;
      end else begin
         if (chip_erase_done_i)
            protect_bits_o <= `PPP_LOCK_RST; // Erase is the only clear path [R17]
         case (state_reg)
            ST_IDLE: begin
               // Session end has priority over any strobe in the same cycle
               if (nop_load) begin
                  fpage_vld_reg <= {PAGE_WORDS{1'b0}}; // Session ends [R10]
                  epage_vld_reg <= {EE_PAGE{1'b0}};
               end else if (flash_latch) begin
                  fpage_vld_reg[flash_slot(addr_lo_reg)] <= 1'b1; // [R5]
               end else if (ee_latch) begin
                  epage_vld_reg[ee_slot(addr_lo_reg)] <= 1'b1; // [R11]
               end else if (wr_fall) begin
                  // The loaded command decides what a write strobe starts
                  case (cmd_reg)
                     `PPP_CMD_WR_FLASH: begin
                        state_reg <= ST_FLASH; // [R8]
                        busy_cnt_reg <= T_FLASH_CYC - 1;
                        ready_not_busy_o <= 1'b0; // [R18]
                     end

                     // EEPROM page write needs the low byte selected
                     `PPP_CMD_WR_EEPROM: begin
                        if (!byte_select_a_i) begin
                           state_reg <= ST_EE; // [R11]
                           busy_cnt_reg <= T_EEPROM_CYC - 1;
                           ready_not_busy_o <= 1'b0;
                        end
                     end

                     // Selects {b,a}: 00 low, 01 high, 10 extended fuse byte
                     `PPP_CMD_WR_FUSE: begin
                        state_reg <= ST_CFG; // [R14]
                        cfg_sel_reg <= {byte_select_b_i, byte_select_a_i};
                        busy_cnt_reg <= T_FUSE_CYC - 1;
                        ready_not_busy_o <= 1'b0;
                     end

                     // A locked part answers with no busy pulse at all
                     `PPP_CMD_WR_LOCK: begin
                        if (!lock_mode3) begin // [R16]
                           state_reg <= ST_CFG; // [R15]
                           cfg_sel_reg <= 2'h3;
                           busy_cnt_reg <= T_FUSE_CYC - 1;
                           ready_not_busy_o <= 1'b0;
                        end
                     end

                     // Strobes under read or no-op commands do nothing
                     default: ;
                  endcase
               end
            end
            default: begin
               // One shared down-counter serves all self-timed writes;
               // ready rises in the cycle after it reaches zero
               // Strobes ignored until the timer runs out [R21]
               if (busy_cnt_reg != 32'h0000_0000) begin
                  busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
               end else begin
                  state_reg <= ST_IDLE;
                  ready_not_busy_o <= 1'b1; // [R18]
                  if (state_reg == ST_FLASH)
                     fpage_vld_reg <= {PAGE_WORDS{1'b0}};
                  if (state_reg == ST_EE)
                     epage_vld_reg <= {EE_PAGE{1'b0}};
                  // Configuration bytes change only at the end of the busy time, the lock byte also on erase
                  if (state_reg == ST_CFG) begin
                     case (cfg_sel_reg)
                        2'h0: fuse_low_o <= data_lo_reg; // [R14]
                        2'h1: fuse_high_o <= data_lo_reg;
                        2'h2: fuse_ext_o <= data_lo_reg;
                        // Zeros program; programmed bits stay programmed [R15] [R17]
                        default: protect_bits_o <= protect_bits_o & data_lo_reg;
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // Commit the page at the end of the programming time. The memories model
   // the array contents only; a real array would also need its erase cycle.
   always @(posedge clk_sys_i) begin
      // Flash: each latched word lands in the page picked by the address [R6]
      if (state_reg == ST_FLASH && busy_cnt_reg == 32'h0000_0000) begin
         for (i = 0; i < PAGE_WORDS; i = i + 1)
            if (fpage_vld_reg[i])
               flash_mem[{flash_page(addr), i[WORD_BITS-1:0]}]
                  <= fpage_buf[i]; // [R6] [R8]
      end
      // EEPROM: unlatched bytes of the page keep their old contents
      if (state_reg == ST_EE && busy_cnt_reg == 32'h0000_0000) begin
         for (i = 0; i < EE_PAGE; i = i + 1)
            if (epage_vld_reg[i])
               ee_mem[{ee_page(addr), i[EE_WORD_BITS-1:0]}]
                  <= epage_buf[i]; // [R11]
      end
   end

   // Read path; bus released unless enable low and a read command loaded, the EEPROM read also needing the low byte selected
   // Data and enable are registered, so the bus turns one cycle after
   // the enable pin; the programmer must leave the bus before that.
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_out_o <= 8'h00;
         data_oe_o <= 8'h00;
      end else if (!output_enable_b_i && cmd_reg == `PPP_CMD_RD_FLASH) begin
         data_oe_o <= 8'hff; // [R19]
         data_out_o <= byte_select_a_i ? flash_mem[flash_word(addr)][15:8]
                                       : flash_mem[flash_word(addr)][7:0]; // [R12]
      end else if (!output_enable_b_i && cmd_reg == `PPP_CMD_RD_EEPROM &&
                   !byte_select_a_i) begin
         data_oe_o <= 8'hff; // [R19]
         data_out_o <= ee_mem[addr[EE_AW-1:0]]; // [R13]
      end else begin
         data_oe_o <= 8'h00;
         data_out_o <= 8'h00;
      end
   end
endmodule // ppp_port

// File: verif/ppp_port_assertions.sv
// Checker of the programming port pins, bound into every ppp_port.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ns
module ppp_chk #(
   parameter T_FLASH_CYC = 20,
   parameter T_EEPROM_CYC = 20,
   parameter T_FUSE_CYC = 20
) (
   input wire clk_sys_i,
   input wire rst_b_i,
   input wire write_strobe_b_i,
   input wire output_enable_b_i,
   input wire chip_erase_done_i,
   input wire [7:0] data_oe_o,
   input wire ready_not_busy_o,
   input wire [7:0] fuse_low_o,
   input wire [7:0] fuse_high_o,
   input wire [7:0] fuse_ext_o,
   input wire [7:0] protect_bits_o
);
   reg [31:0] busy_cnt;
   // Busy length counter; cleared while ready so a reset leaves no trace
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i)
         busy_cnt <= 32'h0000_0000;
      else if (ready_not_busy_o)
         busy_cnt <= 32'h0000_0000;
      else
         busy_cnt <= busy_cnt + 32'h0000_0001;
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_busy_end;
      !ready_not_busy_o ##1 ready_not_busy_o;
   endsequence
   property p_busy_len;
      s_busy_end |-> busy_cnt == T_FLASH_CYC || busy_cnt == T_EEPROM_CYC
         || busy_cnt == T_FUSE_CYC;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy time");
   property p_busy_cause;
      $fell(ready_not_busy_o) |-> $past(write_strobe_b_i, 2) && !$past(write_strobe_b_i);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy cause");
   property p_oe_off;
      output_enable_b_i |=> data_oe_o == 8'h00;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("bus driven");
   property p_oe_whole;
      data_oe_o == 8'h00 || data_oe_o == 8'hff;
   endproperty
   a_oe_whole: assert property (p_oe_whole) else $error("bus split");
   property p_fuse_quiet;
      !$stable({fuse_low_o, fuse_high_o, fuse_ext_o})
         |-> !$past(ready_not_busy_o) || !$past(ready_not_busy_o, 2);
   endproperty
   a_fuse_quiet: assert property (p_fuse_quiet) else $error("fuse moved");
   property p_lock_prog;
      !$past(chip_erase_done_i) |-> (protect_bits_o & ~$past(protect_bits_o)) == 8'h00;
   endproperty
   a_lock_prog: assert property (p_lock_prog) else $error("lock bit set");
   property p_lock_mode3;
      protect_bits_o[1:0] == 2'b00 && !chip_erase_done_i |=> $stable(protect_bits_o);
   endproperty
   a_lock_mode3: assert property (p_lock_mode3) else $error("mode 3 moved");
   property p_erase;
      chip_erase_done_i && ready_not_busy_o |=> protect_bits_o == 8'hff;
   endproperty
   a_erase: assert property (p_erase) else $error("erase missed");
endmodule // ppp_chk
bind ppp_port ppp_chk #(.T_FLASH_CYC(T_FLASH_CYC), .T_EEPROM_CYC(T_EEPROM_CYC),
   .T_FUSE_CYC(T_FUSE_CYC)) u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
   .write_strobe_b_i(write_strobe_b_i), .output_enable_b_i(output_enable_b_i),
   .chip_erase_done_i(chip_erase_done_i), .data_oe_o(data_oe_o),
   .ready_not_busy_o(ready_not_busy_o), .fuse_low_o(fuse_low_o),
   .fuse_high_o(fuse_high_o), .fuse_ext_o(fuse_ext_o), .protect_bits_o(protect_bits_o));

// File: verif/ppp_prog_model.sv
// Programmer side of the data bus: resolves both drivers into one level.
// Assumes the bench sets drv_i only while the port is not driving.
`timescale 1ns/1ns
module ppp_prog_model (
   input wire clk_sys_i,
   input wire drv_i,
   input wire [7:0] val_i,
   input wire [7:0] dev_data_i,
   input wire [7:0] dev_oe_i,
   output wire [7:0] bus_o
);
   reg [7:0] last_reg = 8'h00;
   // Undriven bits toggle each cycle so a stale value never looks valid
   assign bus_o = drv_i ? val_i : (dev_oe_i & dev_data_i) | (~dev_oe_i & ~last_reg);
   always @(posedge clk_sys_i) begin
      last_reg <= bus_o;
   end
endmodule // ppp_prog_model

// File: verif/ppp_port_test.sv
// Self-checking bench of the programming port, short timers.
// Assumes pins change at the falling clock edge.
`timescale 1ns/1ns
module ppp_port_test;
   reg clk_sys_i, rst_b_i, lc, ahi, alo, bsa, bsb, pl, wsb, oeb, ced, drv;
   reg [7:0] dv;
   wire [7:0] din, dout, doe, fl, fh, fe, pb;
   wire rdy;
   integer num_errors, comparisons, i, j;
   ppp_port #(.T_FLASH_CYC(20), .T_EEPROM_CYC(20), .T_FUSE_CYC(20)) uut (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .load_clock_pin_i(lc),
      .action_select_hi_i(ahi), .action_select_lo_i(alo), .byte_select_a_i(bsa),
      .byte_select_b_i(bsb), .page_buffer_latch_i(pl), .write_strobe_b_i(wsb),
      .output_enable_b_i(oeb), .data_in_i(din), .data_out_o(dout), .data_oe_o(doe),
      .ready_not_busy_o(rdy), .fuse_low_o(fl), .fuse_high_o(fh), .fuse_ext_o(fe),
      .protect_bits_o(pb), .chip_erase_done_i(ced));
   ppp_prog_model prog (.clk_sys_i(clk_sys_i), .drv_i(drv), .val_i(dv),
      .dev_data_i(dout), .dev_oe_i(doe), .bus_o(din));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("errors %0d comparisons %0d", num_errors, comparisons);
         if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // One load clock pulse with action, byte select and data held around it
   task ld(input [1:0] act, input a, input [7:0] d);
      begin
         {ahi, alo} = act;
         bsa = a;
         dv = d;
         @(negedge clk_sys_i) lc = 1'b1;
         @(negedge clk_sys_i) lc = 1'b0;
      end
   endtask
   task latch;
      begin
         bsa = 1'b1;
         @(negedge clk_sys_i) pl = 1'b1;
         @(negedge clk_sys_i) pl = 1'b0;
      end
   endtask
   task wword(input [7:0] a, input [15:0] w);
      begin
         ld(2'h0, 1'b0, a);
         ld(2'h1, 1'b0, w[7:0]);
         ld(2'h1, 1'b1, w[15:8]);
         latch;
      end
   endtask
   // Write strobe, then ready is looked at once the busy edge has landed
   task wr(input a, input b, input idle);
      begin
         bsa = a;
         bsb = b;
         @(negedge clk_sys_i) wsb = 1'b0;
         @(negedge clk_sys_i) wsb = 1'b1;
         @(negedge clk_sys_i) chk({7'h00, rdy}, {7'h00, idle});
      end
   endtask
   task wait_rdy;
      begin
         i = 0;
         while (rdy !== 1'b1 && i < 200) begin
            @(negedge clk_sys_i);
            i = i + 1;
         end
         if (i == 200) begin
            num_errors = num_errors + 1;
            $display("ERROR %0t ready stuck low", $time);
            close_out;
         end
      end
   endtask
   // Bench lets go of the bus before enabling the port's drivers
   task rd(input a, input [7:0] e);
      begin
         bsa = a;
         drv = 1'b0;
         oeb = 1'b0;
         @(negedge clk_sys_i) chk(din, e);
         chk(doe, 8'hff);
         oeb = 1'b1;
         @(negedge clk_sys_i) chk(doe, 8'h00);
         drv = 1'b1;
      end
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      num_errors = 0;
      comparisons = 0;
      {rst_b_i, lc, ahi, alo, bsa, bsb, pl, wsb, oeb, ced, drv} = 11'h18d;
      dv = 8'h00;
      repeat (4) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      chk(fl & fh & fe & pb, 8'hff);
      chk({7'h00, rdy}, 8'h01);
      $display("test reset done");
      // Last two words of page 5, then a refused load while busy
      ld(2'h2, 1'b0, 8'h10);
      wword(8'h7e, 16'haa55);
      wword(8'h7f, 16'h1234);
      ld(2'h0, 1'b1, 8'h01);
      wr(1'b0, 1'b0, 1'b0);
      ld(2'h0, 1'b0, 8'h00);
      wait_rdy;
      ld(2'h2, 1'b0, 8'h00);
      wr(1'b0, 1'b0, 1'b1);
      ld(2'h2, 1'b0, 8'h02);
      ld(2'h3, 1'b0, 8'h7e);
      rd(1'b0, 8'h34);
      rd(1'b1, 8'h12);
      ld(2'h0, 1'b0, 8'h7e);
      rd(1'b0, 8'h55);
      rd(1'b1, 8'haa);
      $display("test flash done");
      ld(2'h2, 1'b0, 8'h11);
      ld(2'h0, 1'b1, 8'h01);
      ld(2'h0, 1'b0, 8'h05);
      ld(2'h1, 1'b0, 8'hc3);
      latch;
      wr(1'b0, 1'b0, 1'b0);
      wait_rdy;
      ld(2'h2, 1'b0, 8'h03);
      rd(1'b0, 8'hc3);
      $display("test eeprom done");
      // Selects 00, 01 and 10 pick low, high and extended bytes
      ld(2'h2, 1'b0, 8'h40);
      for (j = 0; j < 3; j = j + 1) begin
         ld(2'h1, 1'b0, 8'hf0 ^ j[7:0]);
         wr(j[0], j[1], 1'b0);
         wait_rdy;
      end
      chk(fl, 8'hf0);
      chk(fh, 8'hf1);
      chk(fe, 8'hf2);
      $display("test fuse done");
      ld(2'h2, 1'b0, 8'h20);
      ld(2'h1, 1'b0, 8'hfe);
      wr(1'b0, 1'b0, 1'b0);
      wait_rdy;
      ld(2'h1, 1'b0, 8'hfd);
      wr(1'b0, 1'b0, 1'b0);
      wait_rdy;
      chk(pb, 8'hfc);
      ld(2'h1, 1'b0, 8'h00);
      wr(1'b0, 1'b0, 1'b1);
      chk(pb, 8'hfc);
      @(negedge clk_sys_i) ced = 1'b1;
      @(negedge clk_sys_i) ced = 1'b0;
      chk(pb, 8'hff);
      $display("test lock done");
      close_out;
   end
endmodule // ppp_port_test
